/* File: inc/tpc_pkg.sv */
// Purpose: constants shared by the 16-bit timer/counter with pulse-added PWM
// Assumes: APB register bus with 32-bit data, one word per register
// Notes:   all offsets are byte addresses on the APB bus
package tpc_pkg;
    // register byte offsets
    localparam logic [7:0]  MODE_OFS        = 8'h00;   // timer_mode_register
    localparam logic [7:0]  CMP_OFS         = 8'h04;   // compare_high_byte:compare_low_byte
    localparam logic [7:0]  COUNT_OFS       = 8'h08;   // binary_counter, read only
    localparam logic [7:0]  STAT_OFS        = 8'h0C;   // request flag and pin level
    // timer_mode_register field positions
    localparam int          MODE_EN_BIT     = 0;       // count_enable_flag
    localparam int          MODE_CKS_LSB    = 1;       // clock_select_field, 3 bits
    localparam int          MODE_PWM_BIT    = 4;       // pwm_select_flag
    // status field positions
    localparam int          STAT_IRQ_BIT    = 0;       // request flag, write one to clear
    localparam int          STAT_PIN_BIT    = 1;       // present level of the output pin
    // reset values
    localparam logic [4:0]  MODE_RST        = 5'h00;
    localparam logic [15:0] CMP_RST         = 16'hFFFF;
    localparam logic [15:0] COUNT_RST       = 16'h0000;
    // prescaler terminal counts
    localparam logic [3:0]  DIV4_LAST       = 4'h3;    // low two bits of divider
    localparam logic [3:0]  DIV16_LAST      = 4'hF;
    // pwm constants
    localparam logic [7:0]  PWM_TOP         = 8'hFF;   // last count of the 8-bit period
    localparam logic [7:0]  PWM_DEAD        = 8'hFF;   // low byte value that holds pin low
    // clock_select_field encodings
    typedef enum logic [2:0] {
        CKS_OSC      = 3'h0,   // oscillator clock, every system cycle
        CKS_DIV4     = 3'h1,   // system_clock_div by four
        CKS_DIV16    = 3'h2,   // system_clock_div by sixteen
        CKS_EVT_RAW  = 3'h3,   // event pin edge, shortest path
        CKS_EVT_SYNC = 3'h4    // event pin edge, resynchronised to system clock
    } tpc_cks_t;
endpackage

/* File: core/tpc_evsync.sv */
// Purpose: bring the event pin into the system clock domain and find edges
// Assumes: EVENT pin is asynchronous to the system clock
// Notes:   the synchronised edge lags the raw edge by exactly one cycle
`timescale 1ns/100ps
module tpc_evsync (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // pin and edges
    input  wire logic pin,
    output logic      raw_evt,
    output logic      sync_evt
);
    import tpc_pkg::*;

    logic [3:0] sh_ff;        // stage 0 is the metastable catcher
    logic [3:0] nxt_sh;       // next shift contents

    // shift the pin through four stages
    always_comb begin
        nxt_sh = {sh_ff[2:0], pin};
    end

    // register only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sh_ff <= 4'h0;    // cleared chain reads as a low pin
        end else begin
            sh_ff <= nxt_sh;
        end
    end

    // raw edge uses stages 1 and 2, synced edge one stage later
    always_comb begin
        raw_evt  = sh_ff[1] & ~sh_ff[2];
        sync_evt = sh_ff[2] & ~sh_ff[3]; // R10
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_sync_lag;
        raw_evt |=> sync_evt;
    endproperty
    a_sync_lag: assert property (p_sync_lag) else $error("synced edge not one cycle late"); // R10
endmodule // tpc_evsync

/* File: core/tpc_pwmadd.sv */
// Purpose: decide whether the current pwm period gets one extra high count
// Assumes: period index advances once per 8-bit pwm wrap
// Notes:   each bit of the high byte owns a disjoint set of period positions
`timescale 1ns/100ps
module tpc_pwmadd (
    // clock and reset, for the checks only
    input  wire logic       clk,
    input  wire logic       rst,
    // position control
    input  wire logic [7:0] hi_byte,
    input  wire logic [7:0] period_index,
    output logic            add_pulse
);
    import tpc_pkg::*;

    logic [7:0] hit;          // one term per high-byte bit

    // bit k claims periods whose lowest set index bit is 7-k
    genvar k;
    generate
        for (k = 0; k < 8; k++) begin : g_pos
            localparam int SH = 7 - k;
            always_comb begin
                hit[k] = hi_byte[k]
                    && (period_index[SH] == 1'b1)
                    && ((period_index & ((8'h01 << SH) - 8'h01)) == 8'h00); // R19
            end
        end
    endgenerate

    // positions of all set bits combine
    always_comb begin
        add_pulse = |hit; // R17 R18
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_no_add;
        (hi_byte == 8'h00) |-> !add_pulse;
    endproperty
    a_no_add: assert property (p_no_add) else $error("pulse added with zero high byte"); // R18

    property p_lsb_pos;
        (hi_byte == 8'h01) |-> (add_pulse == (period_index == 8'h80));
    endproperty
    a_lsb_pos: assert property (p_lsb_pos) else $error("low bit added at wrong period"); // R19
endmodule // tpc_pwmadd

/* File: core/tpc_timer16.sv */
// Purpose: 16-bit timer, event counter, pulse output and pulse-added pwm
// Assumes: APB slave with zero wait states, single system clock
// Notes:   event pin passes two flip-flops before any logic reads it
`timescale 1ns/100ps

// Function
// R1 - counter runs only while enable flag set
// R2 - clock field picks osc, div4 or div16
// R3 - enabling starts counter from zero
// R4 - match sets request, clears counter, continues
// R5 - compare below count wraps before matching
// R6 - change enable flag in separate write
// R7 - compare write while stopped clears counter
// R8 - software clears request before rerunning timer
// R9 - event mode picks raw or synced pin
// R10 - synced event edges resynchronised to clock
// R11 - synced event source cannot wake device
// R12 - pulse mode toggles pin each match
// R13 - software routes port bit to timer
// R14 - pwm flag selects pulse-added pwm
// R15 - pwm counts 8 bits, high until match
// R16 - low byte 0xFF holds pwm low
// R17 - extra high count over 256 periods
// R18 - zero high byte adds no pulse
// R19 - high byte bits map to period positions
// R20 - compare written in one 16-bit access
module tpc_timer16 (
    // clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RESET,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // pins
    input  wire logic        EVENT_PULSE_PIN,
    output logic             PWM_OUTPUT,
    // to the interrupt and power controllers
    output logic             IRQ_REQ,
    output logic             WAKE_REQ
);
    import tpc_pkg::*;

    // register state
    logic              count_enable_flag_ff;   // count_enable_flag
    logic [2:0]        clock_select_field_ff;  // clock_select_field
    logic              pwm_select_flag_ff;     // pwm_select_flag
    logic [15:0]       compare_ff;             // high byte : low byte
    logic [15:0]       binary_counter_ff;      // binary_counter
    logic              irq_ff;                 // timer request flag
    logic              pin_ff;                 // output pin level
    logic              wake_ff;                // wake pulse
    logic [7:0]        period_index_ff;        // pwm period number
    logic [3:0]        div_ff;                 // free prescaler
    logic [31:0]       prdata_ff;              // read data, loaded in setup
    logic              slverr_ff;              // unmapped address flag
    // next values
    logic              nxt_en;
    logic [2:0]        nxt_cks;
    logic              nxt_pwm;
    logic [15:0]       nxt_cmp;
    logic [15:0]       nxt_cnt;
    logic              nxt_irq;
    logic              nxt_pin;
    logic              nxt_wake;
    logic [7:0]        nxt_tn;
    logic [3:0]        nxt_div;
    logic [31:0]       nxt_prdata;
    logic              nxt_slverr;
    // strobes
    logic              wr_acc;                 // write taken this edge
    logic              setup;                  // first apb cycle
    logic              mode_wr;
    logic              cmp_wr;
    logic              stat_wr;
    logic              en_rise;                // enable written 0 -> 1
    logic              tick4;
    logic              tick16;
    logic              raw_evt;
    logic              sync_evt;
    logic              tick;                   // selected count clock
    logic              match;                  // 16-bit compare hit
    logic              add_pulse;
    logic              pwm_hi;                 // pwm level from count

    // register index from address; 4 means unmapped
    function automatic logic [2:0] reg_sel(input logic [7:0] a);
        case (a)
            MODE_OFS:  reg_sel = 3'h0;
            CMP_OFS:   reg_sel = 3'h1;
            COUNT_OFS: reg_sel = 3'h2;
            STAT_OFS:  reg_sel = 3'h3;
            default:   reg_sel = 3'h4;
        endcase
    endfunction

    // event pin synchroniser and edge finder
    tpc_evsync u_sync (
        .clk      (SYS_CLK),
        .rst      (RESET),
        .pin      (EVENT_PULSE_PIN),
        .raw_evt  (raw_evt),
        .sync_evt (sync_evt)
    );

    // added-pulse position decoder
    tpc_pwmadd u_add (
        .clk          (SYS_CLK),
        .rst          (RESET),
        .hi_byte      (compare_ff[15:8]),
        .period_index (period_index_ff),
        .add_pulse    (add_pulse)
    );

    // bus decode; zero wait states so PREADY is always high
    always_comb begin
        PREADY  = 1'b1;
        setup   = PSEL & ~PENABLE;
        wr_acc  = PSEL & PENABLE & PWRITE;
        mode_wr = wr_acc && (reg_sel(PADDR) == 3'h0);
        cmp_wr  = wr_acc && (reg_sel(PADDR) == 3'h1); // R20
        stat_wr = wr_acc && (reg_sel(PADDR) == 3'h3);
        en_rise = mode_wr && PWDATA[MODE_EN_BIT] && !count_enable_flag_ff;
    end

    // read data is captured in setup so PRDATA comes from flip-flops
    always_comb begin
        nxt_prdata = prdata_ff;
        nxt_slverr = slverr_ff;
        if (setup) begin
            nxt_prdata = 32'h0000_0000;
            nxt_slverr = 1'b0;
            case (reg_sel(PADDR))
                3'h0: nxt_prdata[4:0] = {pwm_select_flag_ff, clock_select_field_ff,
                                         count_enable_flag_ff};
                3'h1: nxt_prdata[15:0] = compare_ff;
                3'h2: nxt_prdata[15:0] = binary_counter_ff;
                3'h3: begin
                    nxt_prdata[STAT_IRQ_BIT] = irq_ff;
                    nxt_prdata[STAT_PIN_BIT] = pin_ff;
                end
                default: nxt_slverr = 1'b1;   // unmapped: error, data zero
            endcase
        end
    end

    // control registers; enable is best written alone to avoid a stray count
    always_comb begin
        nxt_en  = count_enable_flag_ff;
        nxt_cks = clock_select_field_ff;
        nxt_pwm = pwm_select_flag_ff;
        nxt_cmp = compare_ff;
        if (mode_wr) begin
            nxt_en  = PWDATA[MODE_EN_BIT]; // R1 R6
            nxt_cks = PWDATA[MODE_CKS_LSB +: 3];
            nxt_pwm = PWDATA[MODE_PWM_BIT]; // R14
        end
        if (cmp_wr) begin
            nxt_cmp = PWDATA[15:0];   // both bytes in one access
        end
    end

    // prescaler runs free; slower rates are single-cycle enables
    always_comb begin
        nxt_div = div_ff + 4'h1;
        tick4   = (div_ff[1:0] == DIV4_LAST[1:0]);
        tick16  = (div_ff == DIV16_LAST);
    end

    // count source select
    always_comb begin
        case (clock_select_field_ff)
            CKS_OSC:      tick = 1'b1; // R2
            CKS_DIV4:     tick = tick4; // R2
            CKS_DIV16:    tick = tick16; // R2
            CKS_EVT_RAW:  tick = raw_evt; // R9
            CKS_EVT_SYNC: tick = sync_evt; // R9 R10
            default:      tick = 1'b0;    // spare codes do not count
        endcase
    end

    // pwm level: high up to the low byte, one count longer in added periods
    always_comb begin
        pwm_hi = 1'b0;
        if (compare_ff[7:0] != PWM_DEAD) begin // R16
            pwm_hi = (binary_counter_ff[7:0] <= compare_ff[7:0])
                  || (add_pulse
                      && (binary_counter_ff[7:0] == compare_ff[7:0] + 8'h01)); // R15 R17
        end
    end

    // counter, request flag, pin and period index
    always_comb begin
        nxt_cnt  = binary_counter_ff;
        nxt_tn   = period_index_ff;
        match    = 1'b0;
        if (cmp_wr && !count_enable_flag_ff) begin
            nxt_cnt = COUNT_RST; // R7
        end else if (en_rise) begin
            nxt_cnt = COUNT_RST; // R3
            nxt_tn  = 8'h00;
        end else if (count_enable_flag_ff && tick) begin // R1
            if (pwm_select_flag_ff) begin
                nxt_cnt = {8'h00, binary_counter_ff[7:0] + 8'h01}; // R15
                if (binary_counter_ff[7:0] == PWM_TOP) begin
                    nxt_tn = period_index_ff + 8'h01; // R17
                end
            end else if (binary_counter_ff == compare_ff) begin
                nxt_cnt = COUNT_RST; // R4
                match   = 1'b1;
            end else begin
                nxt_cnt = binary_counter_ff + 16'h0001; // R3 R5
            end
        end
        // set wins over a clear in the same cycle
        nxt_irq = (irq_ff & ~(stat_wr & PWDATA[STAT_IRQ_BIT])) | match; // R4 R8
        // pulse mode toggles, pwm mode follows the count
        if (pwm_select_flag_ff) begin
            nxt_pin = pwm_hi & count_enable_flag_ff;
        end else begin
            nxt_pin = pin_ff ^ match; // R12
        end
        // a synced event source cannot bring the part out of low power
        nxt_wake = match && (clock_select_field_ff != CKS_EVT_SYNC); // R11
    end

    // state registers
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            count_enable_flag_ff  <= MODE_RST[MODE_EN_BIT];
            clock_select_field_ff <= MODE_RST[MODE_CKS_LSB +: 3];
            pwm_select_flag_ff    <= MODE_RST[MODE_PWM_BIT];
            compare_ff            <= CMP_RST;
            binary_counter_ff     <= COUNT_RST;
            irq_ff                <= 1'b0;
            pin_ff                <= 1'b0;
            wake_ff               <= 1'b0;
            period_index_ff       <= 8'h00;
            div_ff                <= 4'h0;
            prdata_ff             <= 32'h0000_0000;
            slverr_ff             <= 1'b0;
        end else begin
            count_enable_flag_ff  <= nxt_en;
            clock_select_field_ff <= nxt_cks;
            pwm_select_flag_ff    <= nxt_pwm;
            compare_ff            <= nxt_cmp;
            binary_counter_ff     <= nxt_cnt;
            irq_ff                <= nxt_irq;
            pin_ff                <= nxt_pin;
            wake_ff               <= nxt_wake;
            period_index_ff       <= nxt_tn;
            div_ff                <= nxt_div;
            prdata_ff             <= nxt_prdata;
            slverr_ff             <= nxt_slverr;
        end
    end

    // outputs
    always_comb begin
        PRDATA     = prdata_ff;
        PSLVERR    = slverr_ff & PSEL & PENABLE;
        PWM_OUTPUT = pin_ff;
        IRQ_REQ    = irq_ff;
        WAKE_REQ   = wake_ff;
    end

    // checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    sequence s_div4_gap;
        !tick4 ##1 !tick4 ##1 !tick4 ##1 tick4;
    endsequence

    property p_div4;
        tick4 |=> s_div4_gap;
    endproperty
    a_div4: assert property (p_div4) else $error("div4 enable spacing wrong"); // R2

    property p_stopped;
        (!count_enable_flag_ff && !cmp_wr && !en_rise) |=> $stable(binary_counter_ff);
    endproperty
    a_stopped: assert property (p_stopped) else $error("counter moved while stopped"); // R1

    property p_start;
        en_rise |=> (binary_counter_ff == 16'h0000) && count_enable_flag_ff;
    endproperty
    a_start: assert property (p_start) else $error("start did not clear counter"); // R3

    sequence s_after_match;
        (binary_counter_ff == 16'h0000) && irq_ff;
    endsequence

    property p_match;
        match |=> s_after_match;
    endproperty
    a_match: assert property (p_match) else $error("match did not clear and flag"); // R4

    property p_wrap;
        (count_enable_flag_ff && tick && !pwm_select_flag_ff && !mode_wr && !cmp_wr
         && binary_counter_ff == 16'hFFFF && compare_ff != 16'hFFFF)
        |=> (binary_counter_ff == 16'h0000) && !$rose(irq_ff);
    endproperty
    a_wrap: assert property (p_wrap) else $error("full-range wrap wrong"); // R5

    property p_cmp_clear;
        (cmp_wr && !count_enable_flag_ff) |=> (binary_counter_ff == 16'h0000);
    endproperty
    a_cmp_clear: assert property (p_cmp_clear) else $error("stopped compare write kept count"); // R7

    property p_toggle;
        (match && !pwm_select_flag_ff) |=> (pin_ff != $past(pin_ff));
    endproperty
    a_toggle: assert property (p_toggle) else $error("pin did not toggle on match"); // R12

    property p_pwm_dead;
        (pwm_select_flag_ff && compare_ff[7:0] == PWM_DEAD) |=> !pin_ff;
    endproperty
    a_pwm_dead: assert property (p_pwm_dead) else $error("pwm pin high with dead value"); // R16

    property p_pwm_roll;
        (pwm_select_flag_ff && count_enable_flag_ff && tick && !mode_wr && !cmp_wr
         && binary_counter_ff[7:0] == PWM_TOP)
        |=> (binary_counter_ff == 16'h0000) && (period_index_ff == $past(period_index_ff) + 8'h01);
    endproperty
    a_pwm_roll: assert property (p_pwm_roll) else $error("pwm period roll wrong"); // R15 R17

    property p_no_wake;
        (clock_select_field_ff == CKS_EVT_SYNC) |=> !wake_ff;
    endproperty
    a_no_wake: assert property (p_no_wake) else $error("wake from synced event source"); // R11
endmodule // tpc_timer16

/* File: test/tpc_timer16_bench.sv */
// Purpose: self-checking bench for the 16-bit timer/counter with pulse-added pwm
// Assumes: zero wait APB slave, 20 MHz system clock
// Notes:   pwm duty is summed over whole repetition windows, so phase is irrelevant
`timescale 1ns/100ps
module tpc_timer16_bench;
    import tpc_pkg::*;
    logic        sys_clk     = 1'b0;    // system clock
    logic        reset       = 1'b1;    // active high reset
    logic        psel        = 1'b0;    // apb master side
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [7:0]  paddr       = 8'h00;
    logic [31:0] pwdata      = 32'h0;
    logic [31:0] prdata;                // apb answer
    logic        pready;
    logic        pslverr;
    logic        evt_pin     = 1'b0;    // event pin stimulus
    logic        pwm_out;               // waveform pin
    logic        irq_req;               // request flag
    logic        wake_req;              // wake pulse
    int          failures    = 0;       // mismatches
    int          check_count = 0;       // comparisons made
    logic [31:0] rd;                    // data of last transfer
    logic        er;                    // error of last transfer

    tpc_timer16 tpc_timer16_i (
        .SYS_CLK(sys_clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .EVENT_PULSE_PIN(evt_pin),
        .PWM_OUTPUT(pwm_out), .IRQ_REQ(irq_req), .WAKE_REQ(wake_req)
    );

    // 50 ns period
    always #25 sys_clk = ~sys_clk;

    // single exit point of the run
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("FAIL at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one transfer; a leading edge keeps release and next setup apart
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            failures++;
            conclude();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    function automatic logic [31:0] md(input logic [2:0] c, input logic p, input logic e);
        return {27'h0, p, c, e};
    endfunction

    // stop, clear flag, set mode, compare, then enable in a write of its own
    task automatic setup(input logic [2:0] c, input logic p, input logic [31:0] cmp);
        wr(MODE_OFS, 32'h0);
        wr(STAT_OFS, 32'h1);
        wr(MODE_OFS, md(c, p, 1'b0));
        wr(CMP_OFS, cmp);
        wr(MODE_OFS, md(c, p, 1'b1));
    endtask

    // edges until the wake pulse, bounded
    task automatic wait_wake(output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wake_req !== 1'b1 && n < 2000);
        if (n >= 2000) begin
            failures++;
            conclude();
        end
    endtask

    // one event pulse, noting any wake pulse meanwhile
    task automatic pulse(output logic w);
        w = 1'b0;
        for (int j = 0; j < 12; j++) begin
            @(posedge sys_clk);
            evt_pin <= (j < 4);
            w = w | wake_req;
        end
    endtask

    task automatic t_reset();
        rdc(MODE_OFS, {27'h0, MODE_RST});
        rdc(CMP_OFS, {16'h0, CMP_RST});
        rdc(COUNT_OFS, {16'h0, COUNT_RST});
        wr(COUNT_OFS, 32'h5);
        rdc(COUNT_OFS, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        $display("test reset done");
    endtask

    // match period scales with source; pin toggles once per match
    task automatic t_rate();
        int   n;
        logic p0;
        for (int i = 0; i < 3; i++) begin
            setup(3'(i), 1'b0, 32'h5);
            wait_wake(n);
            p0 = pwm_out;
            wait_wake(n);
            chk(32'(n), 32'(6 << (2 * i)));
            chk({31'h0, pwm_out}, {31'h0, ~p0});
        end
        wr(MODE_OFS, 32'h0);
        chk({31'h0, irq_req}, 32'h1);
        wr(STAT_OFS, 32'h1 << STAT_IRQ_BIT);
        @(posedge sys_clk);
        chk({31'h0, irq_req}, 32'h0);
        $display("test rate done");
    endtask

    task automatic t_start();
        logic [31:0] c0;
        logic        seen;
        int          n;
        setup(CKS_OSC, 1'b0, 32'hFFFF);
        repeat (30) @(posedge sys_clk);
        wr(MODE_OFS, 32'h0);
        apb(1'b0, COUNT_OFS, 32'h0);
        c0 = rd;
        chk({31'h0, c0 > 32'h10}, 32'h1);
        repeat (20) @(posedge sys_clk);
        rdc(COUNT_OFS, c0);
        wr(MODE_OFS, md(3'h5, 1'b0, 1'b0));
        wr(MODE_OFS, md(3'h5, 1'b0, 1'b1));
        rdc(COUNT_OFS, 32'h0);
        setup(CKS_OSC, 1'b0, 32'hFFFF);
        repeat (20) @(posedge sys_clk);
        wr(MODE_OFS, 32'h0);
        wr(CMP_OFS, 32'h1234);
        rdc(COUNT_OFS, 32'h0);
        // compare dropped under a running count: no match before wrap
        setup(CKS_OSC, 1'b0, 32'hFFFF);
        repeat (40) @(posedge sys_clk);
        wr(CMP_OFS, 32'h3);
        seen = 1'b0;
        repeat (300) begin
            @(posedge sys_clk);
            seen = seen | irq_req;
        end
        chk({31'h0, seen}, 32'h0);
        apb(1'b0, COUNT_OFS, 32'h0);
        chk({31'h0, rd > 32'h100}, 32'h1);
        // no match until the count wraps through zero and climbs to 3
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (irq_req !== 1'b1 && n < 66000);
        if (n >= 66000) begin
            failures++;
            conclude();
        end
        chk(32'(n), 32'h0001_0003 - rd);
        $display("test start done");
    endtask

    // raw then synced event source; only raw may wake
    task automatic t_event();
        logic w;
        for (int k = 0; k < 2; k++) begin
            setup(k == 0 ? CKS_EVT_RAW : CKS_EVT_SYNC, 1'b0, 32'h2);
            pulse(w);
            pulse(w);
            rdc(COUNT_OFS, 32'h2);
            pulse(w);
            rdc(COUNT_OFS, 32'h0);
            chk({31'h0, irq_req}, 32'h1);
            chk({31'h0, w}, 32'(k == 0));
        end
        $display("test event done");
    endtask

    // high counts summed over whole add-pattern windows
    task automatic t_pwm();
        logic [15:0] cfg [4];
        int          win [4];
        int          exp [4];
        int          hi;
        cfg = '{16'h003F, 16'h00FF, 16'h803F, 16'hC03F};
        win = '{1, 1, 2, 4};
        exp = '{64, 0, 129, 259};
        for (int i = 0; i < 4; i++) begin
            setup(CKS_OSC, 1'b1, {16'h0, cfg[i]});
            repeat (600) @(posedge sys_clk);
            hi = 0;
            repeat (256 * win[i]) begin
                @(posedge sys_clk);
                hi = hi + int'(pwm_out === 1'b1);
            end
            chk(32'(hi), 32'(exp[i]));
            chk({31'h0, irq_req}, 32'h0);
            if (i == 1) begin
                rdc(STAT_OFS, 32'h0);
            end
        end
        $display("test pwm done");
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset();
        t_rate();
        t_start();
        t_event();
        t_pwm();
        conclude();
    end
endmodule // tpc_timer16_bench
